//--- rtl/cspr_device.sv
// Charger end: answers request pulses with a status pulse burst
// What this block does
// - Host request: low pulse of 200 ns minimum
// - After request rising edge, wait delay, then reply
// - Reply pulses spaced at fixed period
// - Line active low, only pulled low, else released
// - Same wire carries request then reply
// - One reply per valid-width request received while idle, count encodes state
// - Host decodes counts; 1-3 faults, 4 unused
// - Adapter states use counts 5 to 12
// - USB high-current states use counts 13 to 17
// - USB low-current states use counts 18 to 22
// - Invalid state replies with count 23
// - Host keeps request shorter than maximum width
// - Over-voltage fault reported for any source, including none, when there is no temperature fault
// - Watchdog timeouts only in adapter charging
`timescale 1ns/1ns
`default_nettype none
module cspr_device (
	input wire logic core_clk,
	input wire logic reset,
	cspr_link_if.device link,
	input wire logic chip_over_temp,
	input wire logic batt_temp_fault,
	input wire logic over_voltage,
	input wire cspr_pkg::cspr_source_type charge_source,
	input wire cspr_pkg::cspr_phase_type charge_phase,
	input wire logic watchdog_expired,
	input wire logic thermal_loop_active,
	output logic reply_busy,
	output logic [4:0] last_count
);
	// ----------------------------------------
	// Timer limits, sized to the timer
	// ----------------------------------------
	localparam logic [15:0] TIMER_ONE = 16'h0001;
	localparam logic [15:0] REQ_MIN = 16'(cspr_pkg::REQUEST_PULSE_MIN_CYC);
	localparam logic [15:0] REQ_MAX = 16'(cspr_pkg::REQUEST_PULSE_MAX_CYC);
	localparam logic [15:0] DELAY_LAST = 16'(cspr_pkg::REPORT_START_DELAY_CYC - 1);
	localparam logic [15:0] PULSE_LOW = 16'(cspr_pkg::REPORT_PULSE_LOW_CYC);
	localparam logic [15:0] PERIOD_LAST = 16'(cspr_pkg::REPORT_PULSE_PERIOD_CYC - 1);

	// ----------------------------------------
	// Request width check
	// ----------------------------------------
	// Low time in samples is the timer plus one when the line rises
	function automatic logic req_width_ok(input logic [15:0] t);
		logic [15:0] n;
		n = 16'(t + TIMER_ONE);
		return n >= REQ_MIN && n < REQ_MAX;
	endfunction

	// ----------------------------------------
	// Status to pulse count
	// ----------------------------------------
	function automatic logic [4:0] status_count(
		input logic ct, input logic bt, input logic ov,
		input cspr_pkg::cspr_source_type src, input cspr_pkg::cspr_phase_type ph,
		input logic wd, input logic tl);
		logic [4:0] c;
		c = cspr_pkg::CNT_REPORT_ERROR;
		if (ct) begin
			c = cspr_pkg::CNT_CHIP_OVER_TEMP;
		end else if (bt) begin
			c = cspr_pkg::CNT_BATT_TEMP_FAULT;
		end else if (ov) begin
			c = cspr_pkg::CNT_OVER_VOLTAGE;
		end else if (src == cspr_pkg::CSPR_SRC_ADAPTER) begin
			case (ph)
				cspr_pkg::CSPR_PH_COND: c = wd ? 5'h05 : 5'h06;
				cspr_pkg::CSPR_PH_CC: c = wd ? 5'h07 : (tl ? 5'h08 : 5'h09);
				cspr_pkg::CSPR_PH_CV: c = wd ? 5'h0a : 5'h0b;
				cspr_pkg::CSPR_PH_DONE: c = cspr_pkg::CNT_ADAPTER_LAST;
				default: c = cspr_pkg::CNT_REPORT_ERROR;
			endcase
		end else if (src == cspr_pkg::CSPR_SRC_USB_HIGH ||
			src == cspr_pkg::CSPR_SRC_USB_LOW) begin
			// Watchdog input ignored: no watchdog runs on USB
			case (ph)
				cspr_pkg::CSPR_PH_COND: c = 5'h00;
				cspr_pkg::CSPR_PH_CC_LIMITED: c = 5'h01;
				cspr_pkg::CSPR_PH_CC: c = 5'h02;
				cspr_pkg::CSPR_PH_CV: c = 5'h03;
				cspr_pkg::CSPR_PH_DONE: c = 5'h04;
				default: c = 5'h1f;
			endcase
			if (c == 5'h1f) begin
				c = cspr_pkg::CNT_REPORT_ERROR;
			end else if (src == cspr_pkg::CSPR_SRC_USB_HIGH) begin
				c = 5'(c + cspr_pkg::CNT_USB_HIGH_FIRST);
			end else begin
				c = 5'(c + cspr_pkg::CNT_USB_LOW_FIRST);
			end
		end
		return c;
	endfunction

	// ----------------------------------------
	// Reply sequencer
	// ----------------------------------------
	typedef enum logic [3:0] {
		CSPR_D_IDLE = 4'b0001,
		CSPR_D_REQ = 4'b0010,
		CSPR_D_DELAY = 4'b0100,
		CSPR_D_PULSE = 4'b1000
	} cspr_dstate_type;

	cspr_dstate_type state_q, state_d;
	logic [15:0] timer_q, timer_d;
	logic [4:0] remain_q, remain_d;
	logic drive_low_q, drive_low_d;
	logic busy_q, busy_d;
	logic [4:0] last_q, last_d;

	always_comb begin
		state_d = state_q;
		timer_d = timer_q;
		remain_d = remain_q;
		drive_low_d = 1'b0;
		busy_d = 1'b1;
		last_d = last_q;
		case (state_q)
			CSPR_D_IDLE: begin
				busy_d = 1'b0;
				timer_d = 16'h0000;
				if (!link.line) begin
					state_d = CSPR_D_REQ;
					busy_d = 1'b1;
				end
			end
			CSPR_D_REQ: begin
				timer_d = 16'(timer_q + 16'h0001);
				if (link.line) begin
					// Too short or too long: treated as a glitch, no reply
					if (!req_width_ok(timer_q)) begin
						state_d = CSPR_D_IDLE;
						busy_d = 1'b0;
					end else begin
						state_d = CSPR_D_DELAY;
						timer_d = 16'h0000;
						remain_d = status_count(chip_over_temp, batt_temp_fault,
							over_voltage, charge_source, charge_phase,
							watchdog_expired, thermal_loop_active);
						last_d = remain_d;
					end
				end else if (timer_q == 16'hffff) begin
					timer_d = timer_q;
				end
			end
			CSPR_D_DELAY: begin
				timer_d = 16'(timer_q + 16'h0001);
				if (timer_q == DELAY_LAST) begin
					state_d = CSPR_D_PULSE;
					timer_d = 16'h0000;
					drive_low_d = 1'b1;
				end
			end
			CSPR_D_PULSE: begin
				// Line is not watched here, so own pulses never retrigger
				timer_d = 16'(timer_q + 16'h0001);
				drive_low_d = timer_d < PULSE_LOW;
				if (timer_q == PERIOD_LAST) begin
					timer_d = 16'h0000;
					remain_d = 5'(remain_q - 5'h01);
					if (remain_q == 5'h01) begin
						state_d = CSPR_D_IDLE;
						drive_low_d = 1'b0;
					end else begin
						drive_low_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = CSPR_D_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= CSPR_D_IDLE;
			timer_q <= 16'h0000;
			remain_q <= 5'h00;
			drive_low_q <= 1'b0;
			busy_q <= 1'b0;
			last_q <= 5'h00;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			remain_q <= remain_d;
			drive_low_q <= drive_low_d;
			busy_q <= busy_d;
			last_q <= last_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: data always 0, enable only while pulling low
	assign link.dev_out = 1'b0;
	assign link.dev_low_oe = drive_low_q;
	assign reply_busy = busy_q;
	assign last_count = last_q;
endmodule : cspr_device // cspr_device
`default_nettype wire

//--- rtl/cspr_pkg.sv
// Constants and types shared by both ends of the charge status pulse link
package cspr_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int REQUEST_PULSE_MIN_WIDTH_NS = 200;
	localparam int REQUEST_PULSE_MIN_CYC =
		(REQUEST_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Report delay, pulse period and maximum request width are not printed
	localparam int REPORT_START_DELAY_NS = 1000;
	localparam int REPORT_START_DELAY_CYC = REPORT_START_DELAY_NS / CLK_PERIOD_NS;
	localparam int REPORT_PULSE_PERIOD_NS = 800;
	localparam int REPORT_PULSE_PERIOD_CYC = REPORT_PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int REPORT_PULSE_LOW_CYC = REPORT_PULSE_PERIOD_CYC / 2;
	localparam int REQUEST_PULSE_MAX_NS = 4000;
	localparam int REQUEST_PULSE_MAX_CYC = REQUEST_PULSE_MAX_NS / CLK_PERIOD_NS;
	// Host waits this long after the last pulse before closing the count
	localparam int REPORT_END_GAP_CYC = 3 * REPORT_PULSE_PERIOD_CYC;
	localparam int TIMER_W = 16;
	// ----------------------------------------
	// Pulse counts
	// ----------------------------------------
	localparam int COUNT_W = 5;
	localparam logic [4:0] CNT_CHIP_OVER_TEMP = 5'h01;
	localparam logic [4:0] CNT_BATT_TEMP_FAULT = 5'h02;
	localparam logic [4:0] CNT_OVER_VOLTAGE = 5'h03;
	localparam logic [4:0] CNT_UNUSED = 5'h04;
	localparam logic [4:0] CNT_ADAPTER_FIRST = 5'h05;
	localparam logic [4:0] CNT_ADAPTER_LAST = 5'h0c;
	localparam logic [4:0] CNT_USB_HIGH_FIRST = 5'h0d;
	localparam logic [4:0] CNT_USB_HIGH_LAST = 5'h11;
	localparam logic [4:0] CNT_USB_LOW_FIRST = 5'h12;
	localparam logic [4:0] CNT_USB_LOW_LAST = 5'h16;
	localparam logic [4:0] CNT_REPORT_ERROR = 5'h17;
	// ----------------------------------------
	// Charger status seen by the device end
	// ----------------------------------------
	typedef enum logic [1:0] {
		CSPR_SRC_NONE = 2'h0,
		CSPR_SRC_ADAPTER = 2'h1,
		CSPR_SRC_USB_HIGH = 2'h2,
		CSPR_SRC_USB_LOW = 2'h3
	} cspr_source_type;
	typedef enum logic [2:0] {
		CSPR_PH_COND = 3'h0,
		CSPR_PH_CC = 3'h1,
		CSPR_PH_CC_LIMITED = 3'h2,
		CSPR_PH_CV = 3'h3,
		CSPR_PH_DONE = 3'h4
	} cspr_phase_type;
	// Host decode result
	typedef enum logic [2:0] {
		CSPR_CLS_NONE = 3'h0,
		CSPR_CLS_FAULT = 3'h1,
		CSPR_CLS_ADAPTER = 3'h2,
		CSPR_CLS_USB_HIGH = 3'h3,
		CSPR_CLS_USB_LOW = 3'h4,
		CSPR_CLS_ERROR = 3'h5
	} cspr_class_type;
endpackage : cspr_pkg

//--- rtl/cspr_link_if.sv
// Shared open-drain status line between charger and host
`timescale 1ns/1ns
`default_nettype none
interface cspr_link_if;
	logic dev_low_oe;
	logic host_low_oe;
	logic dev_out;
	logic host_out;
	logic line;
	// Pull-up idles high; either party may only pull low
	assign line = ~((dev_low_oe & ~dev_out) | (host_low_oe & ~host_out));
	modport device (input line, output dev_low_oe, output dev_out);
	modport host (input line, output host_low_oe, output host_out);
endinterface : cspr_link_if
`default_nettype wire

//--- rtl/cspr_host.sv
// Host end: issues a request pulse and counts the reply burst
`timescale 1ns/1ns
`default_nettype none
module cspr_host (
	input wire logic core_clk,
	input wire logic reset,
	cspr_link_if.host link,
	input wire logic poll_start,
	output logic poll_busy,
	output logic result_valid,
	output logic [4:0] result_count,
	output cspr_pkg::cspr_class_type result_class
);
	// ----------------------------------------
	// Count lookup
	// ----------------------------------------
	function automatic cspr_pkg::cspr_class_type classify(input logic [4:0] n);
		cspr_pkg::cspr_class_type k;
		k = cspr_pkg::CSPR_CLS_ERROR;
		if (n == 5'h00 || n == cspr_pkg::CNT_UNUSED) begin
			k = cspr_pkg::CSPR_CLS_NONE;
		end else if (n <= cspr_pkg::CNT_OVER_VOLTAGE) begin
			k = cspr_pkg::CSPR_CLS_FAULT;
		end else if (n <= cspr_pkg::CNT_ADAPTER_LAST) begin
			k = cspr_pkg::CSPR_CLS_ADAPTER;
		end else if (n <= cspr_pkg::CNT_USB_HIGH_LAST) begin
			k = cspr_pkg::CSPR_CLS_USB_HIGH;
		end else if (n <= cspr_pkg::CNT_USB_LOW_LAST) begin
			k = cspr_pkg::CSPR_CLS_USB_LOW;
		end
		return k;
	endfunction

	// ----------------------------------------
	// Poll sequencer
	// ----------------------------------------
	typedef enum logic [2:0] {
		CSPR_H_IDLE = 3'b001,
		CSPR_H_REQ = 3'b010,
		CSPR_H_LISTEN = 3'b100
	} cspr_hstate_type;

	localparam int REQ_CYC = cspr_pkg::REQUEST_PULSE_MIN_CYC + 1;
	localparam int TIMEOUT_CYC = cspr_pkg::REPORT_START_DELAY_CYC +
		24 * cspr_pkg::REPORT_PULSE_PERIOD_CYC + cspr_pkg::REPORT_END_GAP_CYC;

	cspr_hstate_type state_q, state_d;
	logic [15:0] timer_q, timer_d;
	logic [4:0] count_q, count_d;
	logic line_q, line_d;
	logic low_q, low_d;
	logic busy_q, busy_d;
	logic valid_q, valid_d;
	logic [4:0] res_q, res_d;
	cspr_pkg::cspr_class_type cls_q, cls_d;

	always_comb begin
		state_d = state_q;
		timer_d = 16'(timer_q + 16'h0001);
		count_d = count_q;
		line_d = link.line;
		low_d = 1'b0;
		busy_d = 1'b1;
		valid_d = 1'b0;
		res_d = res_q;
		cls_d = cls_q;
		case (state_q)
			CSPR_H_IDLE: begin
				busy_d = 1'b0;
				timer_d = 16'h0000;
				if (poll_start) begin
					state_d = CSPR_H_REQ;
					low_d = 1'b1;
					busy_d = 1'b1;
				end
			end
			CSPR_H_REQ: begin
				// Held past the minimum, well under the maximum
				low_d = 1'b1;
				if (timer_q == 16'(REQ_CYC - 1)) begin
					state_d = CSPR_H_LISTEN;
					low_d = 1'b0;
					timer_d = 16'h0000;
					count_d = 5'h00;
				end
			end
			CSPR_H_LISTEN: begin
				if (line_q && !link.line) begin
					count_d = 5'(count_q + 5'h01);
				end
				if ((count_q != 5'h00 && timer_q >= 16'(cspr_pkg::REPORT_END_GAP_CYC)) ||
					timer_q == 16'(TIMEOUT_CYC)) begin
					state_d = CSPR_H_IDLE;
					busy_d = 1'b0;
					valid_d = 1'b1;
					res_d = count_q;
					cls_d = classify(count_q);
				end
				if (line_q && !link.line) begin
					timer_d = 16'h0000;
				end
			end
			default: begin
				state_d = CSPR_H_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= CSPR_H_IDLE;
			timer_q <= 16'h0000;
			count_q <= 5'h00;
			line_q <= 1'b1;
			low_q <= 1'b0;
			busy_q <= 1'b0;
			valid_q <= 1'b0;
			res_q <= 5'h00;
			cls_q <= cspr_pkg::CSPR_CLS_NONE;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			count_q <= count_d;
			line_q <= line_d;
			low_q <= low_d;
			busy_q <= busy_d;
			valid_q <= valid_d;
			res_q <= res_d;
			cls_q <= cls_d;
		end
	end

	// Only ever pulls low, released otherwise
	assign link.host_out = 1'b0;
	assign link.host_low_oe = low_q;
	assign poll_busy = busy_q;
	assign result_valid = valid_q;
	assign result_count = res_q;
	assign result_class = cls_q;
endmodule : cspr_host // cspr_host
`default_nettype wire

//--- sim/cspr_link_monitor.sv
// Assertions on the shared status line between both ends
`timescale 1ns/1ns
`default_nettype none
module cspr_link_monitor (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic dev_low_oe,
	input wire logic dev_out,
	input wire logic host_low_oe,
	input wire logic host_out
);
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	logic [15:0] rq_q;
	logic [4:0] np_q;
	// Low run saturates so that long idle spans cannot wrap
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hi_q <= 16'h0000;
			lo_q <= 16'h03e8;
			rq_q <= 16'h0000;
			np_q <= 5'h00;
		end else begin
			hi_q <= dev_low_oe ? hi_q + 16'h0001 : 16'h0000;
			lo_q <= dev_low_oe ? 16'h0000 : (lo_q == 16'h03e8 ? lo_q : lo_q + 16'h0001);
			rq_q <= host_low_oe ? rq_q + 16'h0001 : 16'h0000;
			np_q <= host_low_oe ? 5'h00 : np_q + {4'h0, dev_low_oe && hi_q == 16'h0000};
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	a_dev_pull_only: assert property (dev_low_oe |-> !dev_out)
		else $error("device drives the line high");
	a_host_pull_only: assert property (host_low_oe |-> !host_out)
		else $error("host drives the line high");
	a_pulse_low_width: assert property ($fell(dev_low_oe) |-> hi_q == 16'h0032)
		else $error("reply pulse low time wrong");
	a_pulse_spacing: assert property ($rose(dev_low_oe) |-> np_q == 5'h00 || lo_q == 16'h0032)
		else $error("reply pulse spacing wrong");
	a_start_delay: assert property ($fell(host_low_oe) |-> ##[124:128] $rose(dev_low_oe))
		else $error("reply did not start after the report delay");
	a_no_overlap: assert property (!(dev_low_oe && host_low_oe))
		else $error("both ends pull the line at once");
	a_burst_limit: assert property ($rose(dev_low_oe) |-> np_q < 5'h17)
		else $error("reply burst too long");
	a_req_width: assert property ($fell(host_low_oe) |-> rq_q >= 16'h0019 && rq_q < 16'h01f4)
		else $error("request pulse width out of range");
	c_request: cover property ($fell(host_low_oe));
	c_first_pulse: cover property ($rose(dev_low_oe) && np_q == 5'h00);
	c_error_burst: cover property ($rose(dev_low_oe) && np_q == 5'h16);
endmodule // cspr_link_monitor
`default_nettype wire

//--- sim/cspr_tb_top.sv
// Self-checking bench joining both ends, plus a rogue requester on a second link
`timescale 1ns/1ns
`default_nettype none
module cspr_tb_top;
	logic core_clk, reset, poll_start, ct, bt, ov, wd, tl, prev_b;
	logic reply_busy, poll_busy, result_valid, rb2;
	logic [4:0] last_count, result_count, lc2;
	logic [7:0] rnd;
	cspr_pkg::cspr_source_type src;
	cspr_pkg::cspr_phase_type ph;
	cspr_pkg::cspr_class_type result_class;
	int n_errors = 0;
	int num_checks = 0;
	int n_b = 0;
	cspr_link_if link_a ();
	cspr_link_if link_b ();
	cspr_device cspr_device_i (.core_clk(core_clk), .reset(reset), .link(link_a),
		.chip_over_temp(ct), .batt_temp_fault(bt), .over_voltage(ov), .charge_source(src),
		.charge_phase(ph), .watchdog_expired(wd), .thermal_loop_active(tl),
		.reply_busy(reply_busy), .last_count(last_count));
	cspr_host cspr_host_i (.core_clk(core_clk), .reset(reset), .link(link_a),
		.poll_start(poll_start), .poll_busy(poll_busy), .result_valid(result_valid),
		.result_count(result_count), .result_class(result_class));
	// Second device faces the bench, which breaks the request rules on purpose
	cspr_device cspr_device_b_i (.core_clk(core_clk), .reset(reset), .link(link_b),
		.chip_over_temp(ct), .batt_temp_fault(bt), .over_voltage(ov), .charge_source(src),
		.charge_phase(ph), .watchdog_expired(wd), .thermal_loop_active(tl),
		.reply_busy(rb2), .last_count(lc2));
	cspr_link_monitor cspr_link_monitor_i (.core_clk(core_clk), .reset(reset),
		.dev_low_oe(link_a.dev_low_oe), .dev_out(link_a.dev_out),
		.host_low_oe(link_a.host_low_oe), .host_out(link_a.host_out));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		prev_b <= link_b.dev_low_oe;
		if (link_b.dev_low_oe && !prev_b) n_b++;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [4:0] f_cnt(input logic c, b, o, w, t,
		input cspr_pkg::cspr_source_type s, input cspr_pkg::cspr_phase_type p);
		logic [4:0] k;
		k = p == cspr_pkg::CSPR_PH_CC ? 5'h02 : p == cspr_pkg::CSPR_PH_CC_LIMITED ? 5'h01 : {2'h0, p};
		if (c) return 5'h01;
		if (b) return 5'h02;
		if (o) return 5'h03;
		if (s == cspr_pkg::CSPR_SRC_USB_HIGH) return 5'h0d + k;
		if (s == cspr_pkg::CSPR_SRC_USB_LOW) return 5'h12 + k;
		if (s == cspr_pkg::CSPR_SRC_NONE) return 5'h17;
		case (p)
			cspr_pkg::CSPR_PH_COND: return w ? 5'h05 : 5'h06;
			cspr_pkg::CSPR_PH_CC: return w ? 5'h07 : (t ? 5'h08 : 5'h09);
			cspr_pkg::CSPR_PH_CV: return w ? 5'h0a : 5'h0b;
			cspr_pkg::CSPR_PH_DONE: return 5'h0c;
			default: return 5'h17;
		endcase
	endfunction
	function automatic logic [2:0] f_cls(input logic [4:0] n);
		if (n == 5'h00 || n == 5'h04) return 3'h0;
		if (n < 5'h04) return 3'h1;
		if (n < 5'h0d) return 3'h2;
		if (n < 5'h12) return 3'h3;
		if (n < 5'h17) return 3'h4;
		return 3'h5;
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic poll();
		logic [4:0] e;
		int i;
		e = f_cnt(ct, bt, ov, wd, tl, src, ph);
		i = 0;
		poll_start <= 1'b1;
		@(posedge core_clk);
		poll_start <= 1'b0;
		while (result_valid !== 1'b1 && i < 4000) begin
			@(posedge core_clk);
			i++;
		end
		chk("result_count", {3'h0, result_count}, {3'h0, e});
		chk("result_class", {5'h00, result_class}, {5'h00, f_cls(e)});
		chk("last_count", {3'h0, last_count}, {3'h0, e});
		chk("busy", {6'h00, reply_busy, poll_busy}, 8'h00);
		@(posedge core_clk);
		chk("result_valid", {7'h00, result_valid}, 8'h00);
	endtask
	task automatic rq(input int w, input int gap);
		link_b.host_low_oe <= 1'b1;
		repeat (w) @(posedge core_clk);
		link_b.host_low_oe <= 1'b0;
		repeat (gap) @(posedge core_clk);
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		results();
	end
	initial begin
		int i;
		reset = 1'b1;
		poll_start = 1'b0;
		{ct, bt, ov, wd, tl} = 5'h00;
		rnd = 8'h20;
		src = cspr_pkg::CSPR_SRC_NONE;
		ph = cspr_pkg::CSPR_PH_COND;
		link_b.host_low_oe = 1'b0;
		link_b.host_out = 1'b0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		// Faults stacked to exercise their priority
		for (i = 0; i < 3; i++) begin
			{ct, bt, ov} <= 3'b111 >> i;
			src <= cspr_pkg::CSPR_SRC_ADAPTER;
			ph <= cspr_pkg::CSPR_PH_CC;
			@(posedge core_clk);
			poll();
		end
		{ct, bt, ov} <= 3'b000;
		// Every source and phase; watchdog and thermal loop drawn at random
		for (i = 0; i < 20; i++) begin
			rnd = lfsr(rnd);
			src <= cspr_pkg::cspr_source_type'(i / 5);
			ph <= cspr_pkg::cspr_phase_type'(i % 5);
			wd <= rnd[0] && (i % 5 != 4);
			tl <= rnd[1] && !rnd[0];
			@(posedge core_clk);
			poll();
		end
		// Adapter corners the random draw can miss: counts 6, 7, 9 and 11
		for (i = 0; i < 4; i++) begin
			src <= cspr_pkg::CSPR_SRC_ADAPTER;
			ph <= i == 3 ? cspr_pkg::CSPR_PH_CV :
				(i == 0 ? cspr_pkg::CSPR_PH_COND : cspr_pkg::CSPR_PH_CC);
			wd <= i == 1;
			tl <= 1'b0;
			@(posedge core_clk);
			poll();
		end
		src <= cspr_pkg::CSPR_SRC_USB_LOW;
		ph <= cspr_pkg::CSPR_PH_DONE;
		@(posedge core_clk);
		rq(24, 300);
		rq(500, 300);
		chk("rogue pulses", n_b[7:0], 8'h00);
		// Noise in mid-burst must neither cut nor repeat the reply
		rq(25, 400);
		rq(30, 0);
		i = 0;
		while (rb2 !== 1'b0 && i < 4000) begin
			@(posedge core_clk);
			i++;
		end
		repeat (300) @(posedge core_clk);
		chk("rogue pulses", n_b[7:0], 8'h16);
		chk("rogue last_count", {3'h0, lc2}, 8'h16);
		results();
	end
endmodule // cspr_tb_top
`default_nettype wire
